// *** src/flash_host_defs.svh ***
// constants of the flash host controller: register map, command codes, bit positions, timing
// assumes word-mode flash with 20 address bits and a 16-bit data bus
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// ----------------------------------------
// software register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0c
`define REG_RESULT 8'h10

// ----------------------------------------
// command addresses and codes
// ----------------------------------------
`define UNLOCK_ADDR1 20'h00555
`define UNLOCK_ADDR2 20'h002aa
`define QUERY_ADDR 20'h00055
`define ANY_ADDR 20'h00000
`define PROT_VERIFY_LOW 12'h002
`define CMD_UNLOCK1 16'h00aa
`define CMD_UNLOCK2 16'h0055
`define CMD_PROGRAM 16'h00a0
`define CMD_ERASE_SETUP 16'h0080
`define CMD_SECTOR_ERASE 16'h0030
`define CMD_CHIP_ERASE 16'h0010
`define CMD_RESET 16'h00f0
`define CMD_AUTOSELECT 16'h0090
`define CMD_BYPASS_ENTER 16'h0020
`define CMD_BYPASS_EXIT2 16'h0000
`define CMD_SUSPEND 16'h00b0
`define CMD_RESUME 16'h0030
`define CMD_QUERY 16'h0098

// ----------------------------------------
// status bit positions and fields
// ----------------------------------------
`define ST_FAIL_BIT 5
`define ST_TOGGLE_BIT 6
`define SECT_HI 19
`define SECT_LO 12
`define OP_MSB 3
`define STATUS_PAD 27

// ----------------------------------------
// bus timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define T_SETUP_NS 10
`define T_WE_LOW_NS 35
`define T_ACCESS_NS 70
`define T_HOLD_NS 10

`endif

// *** src/flash_host_pkg.sv ***
// types shared by the flash host controller files
// assumes nothing beyond the package itself
package flash_host_pkg;

   typedef enum logic [3:0] {
      OP_READ = 4'h0,
      OP_PROG = 4'h1,
      OP_SECT_ERASE = 4'h2,
      OP_CHIP_ERASE = 4'h3,
      OP_RESET = 4'h4,
      OP_BYP_ENTER = 4'h5,
      OP_BYP_PROG = 4'h6,
      OP_BYP_EXIT = 4'h7,
      OP_SUSPEND = 4'h8,
      OP_RESUME = 4'h9,
      OP_PROT_VERIFY = 4'ha,
      OP_QUERY = 4'hb
   } op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ISSUE = 3'b010,
      ST_WAIT = 3'b100
   } state_t;

   typedef enum logic [2:0] {
      PH_SEQ = 3'b001,
      PH_POLL = 3'b010,
      PH_FINAL = 3'b100
   } phase_t;

   typedef enum logic [3:0] {
      CY_IDLE = 4'b0001,
      CY_SETUP = 4'b0010,
      CY_STROBE = 4'b0100,
      CY_HOLD = 4'b1000
   } cycle_t;

endpackage

// *** src/flash_bus_cycle.sv ***
// one flash bus cycle, write or read, with chip select framing the strobe
// assumes flash data input is synchronous to mclk; start only when idle
`include "flash_host_defs.svh"

module flash_bus_cycle
   import flash_host_pkg::*;
#(
   parameter int SETUP_CYC = (`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int WE_CYC = (`T_WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int ACC_CYC = (`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   input wire logic write,
   input wire logic [19:0] addr,
   input wire logic [15:0] wdata,
   output logic done,
   output logic [15:0] rdata,
   output logic [19:0] flashAddr,
   output logic [15:0] flashDqOut,
   output logic flashDqOe,
   input wire logic [15:0] flashDqIn,
   output logic flashCeN,
   output logic flashWeN,
   output logic flashOeN
);

   initial begin
      if (SETUP_CYC < 1 || WE_CYC < 1 || ACC_CYC < 1 || ACC_CYC > 255) begin
         $error("flash_bus_cycle: cycle counts out of range");
      end
   end

   cycle_t cyc_r;
   logic [7:0] cnt_r;
   logic write_r;

   // ----------------------------------------
   // strobe sequencing
   // ----------------------------------------
   // address and data settle before the strobe falls and hold past its rise
   always_ff @(posedge mclk) begin
      if (rst) begin
         cyc_r <= CY_IDLE;
         cnt_r <= 8'h00;
         write_r <= 1'b0;
         flashAddr <= 20'h00000;
         flashDqOut <= 16'h0000;
         flashDqOe <= 1'b0;
         flashCeN <= 1'b1;
         flashWeN <= 1'b1;
         flashOeN <= 1'b1;
         done <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         done <= 1'b0;
         unique case (cyc_r)
            CY_IDLE: begin
               if (start) begin
                  flashAddr <= addr;
                  flashDqOut <= wdata;
                  flashDqOe <= write;
                  write_r <= write;
                  flashCeN <= 1'b0;
                  cnt_r <= 8'(SETUP_CYC - 1);
                  cyc_r <= CY_SETUP;
               end
            end
            CY_SETUP: begin
               if (cnt_r == 8'h00) begin
                  // a fresh output-enable fall per read advances the toggle bits
                  flashWeN <= ~write_r;
                  flashOeN <= write_r;
                  cnt_r <= write_r ? 8'(WE_CYC - 1) : 8'(ACC_CYC - 1);
                  cyc_r <= CY_STROBE;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            CY_STROBE: begin
               if (cnt_r == 8'h00) begin
                  if (!write_r) begin
                     rdata <= flashDqIn;
                  end
                  flashWeN <= 1'b1;
                  flashOeN <= 1'b1;
                  cyc_r <= CY_HOLD;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            CY_HOLD: begin
               flashCeN <= 1'b1;
               flashDqOe <= 1'b0;
               done <= 1'b1;
               cyc_r <= CY_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_addr_stable_we;
      @(posedge mclk) disable iff (rst)
      (!flashWeN && $past(!flashWeN)) |-> ($stable(flashAddr) && $stable(flashDqOut));
   endproperty
   a_addr_stable_we: assert property (p_addr_stable_we)
      else $error("address or data moved while write strobe low");

endmodule

// *** src/flash_host_ctrl.sv ***
// host controller for a parallel boot-sector flash: command sequences and status polling
// assumes a word-mode flash on the pins and software on a simple strobe register port
//
// Design decisions made here: the register addresses and strobed register access.
`include "flash_host_defs.svh"

module flash_host_ctrl
   import flash_host_pkg::*;
#(
   parameter int MAX_POLLS = 100000
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic [19:0] flashAddr,
   output logic [15:0] flashDqOut,
   output logic flashDqOe,
   input wire logic [15:0] flashDqIn,
   output logic flashCeN,
   output logic flashWeN,
   output logic flashOeN,
   input wire logic readyBusyN
);

   initial begin
      if (MAX_POLLS < 3) begin
         $error("flash_host_ctrl: MAX_POLLS too small");
      end
   end

   localparam int PW = $clog2(MAX_POLLS + 1);

   // ----------------------------------------
   // command sequence table
   // ----------------------------------------
   // returns {last, read, address, data} of one step of a sequence
   function automatic logic [37:0] seqStep(op_t op, logic [2:0] step, logic [19:0] a,
                                          logic [15:0] d);
      logic [19:0] sectAddr;
      logic [37:0] u1;
      logic [37:0] u2;
      sectAddr = {a[`SECT_HI:`SECT_LO], `PROT_VERIFY_LOW};
      u1 = {2'b00, `UNLOCK_ADDR1, `CMD_UNLOCK1};
      u2 = {2'b00, `UNLOCK_ADDR2, `CMD_UNLOCK2};
      seqStep = {2'b11, a, 16'h0000};
      case (op)
         OP_PROG, OP_SECT_ERASE, OP_CHIP_ERASE, OP_BYP_ENTER, OP_PROT_VERIFY: begin
            if (step == 3'd0 || (step == 3'd3 && op != OP_PROG && op != OP_PROT_VERIFY)) begin
               seqStep = u1;
            end else if (step == 3'd1 || step == 3'd4) begin
               seqStep = u2;
            end else if (step == 3'd2) begin
               case (op)
                  OP_PROG: seqStep = {2'b00, `UNLOCK_ADDR1, `CMD_PROGRAM};
                  OP_BYP_ENTER: seqStep = {2'b10, `UNLOCK_ADDR1, `CMD_BYPASS_ENTER};
                  OP_PROT_VERIFY: seqStep = {2'b00, `UNLOCK_ADDR1, `CMD_AUTOSELECT};
                  default: seqStep = {2'b00, `UNLOCK_ADDR1, `CMD_ERASE_SETUP};
               endcase
            end else if (op == OP_PROG) begin
               seqStep = {2'b10, a, d};
            end else if (op == OP_PROT_VERIFY) begin
               // fourth autoselect cycle is a read
               seqStep = {2'b11, sectAddr, 16'h0000};
            end else if (op == OP_SECT_ERASE) begin
               seqStep = {2'b10, a, `CMD_SECTOR_ERASE};
            end else begin
               seqStep = {2'b10, `UNLOCK_ADDR1, `CMD_CHIP_ERASE};
            end
         end
         OP_BYP_PROG: begin
            seqStep = (step == 3'd0) ? {2'b00, `ANY_ADDR, `CMD_PROGRAM} : {2'b10, a, d};
         end
         OP_BYP_EXIT: begin
            seqStep = (step == 3'd0) ? {2'b00, `ANY_ADDR, `CMD_AUTOSELECT}
                                     : {2'b10, `ANY_ADDR, `CMD_BYPASS_EXIT2};
         end
         OP_RESET: seqStep = {2'b10, `ANY_ADDR, `CMD_RESET};
         OP_SUSPEND: seqStep = {2'b10, `ANY_ADDR, `CMD_SUSPEND};
         OP_RESUME: seqStep = {2'b10, `ANY_ADDR, `CMD_RESUME};
         OP_QUERY: begin
            seqStep = (step == 3'd0) ? {2'b00, `QUERY_ADDR, `CMD_QUERY} : {2'b11, a, 16'h0000};
         end
         default: seqStep = {2'b11, a, 16'h0000};
      endcase
   endfunction

   function automatic logic polls(op_t op);
      polls = (op == OP_PROG || op == OP_SECT_ERASE || op == OP_CHIP_ERASE || op == OP_BYP_PROG);
   endfunction

   state_t state_r;
   phase_t phase_r;
   op_t op_r;
   op_t opIn;
   logic [2:0] step_r;
   logic [19:0] addr_r;
   logic [15:0] data_r;
   logic [15:0] result_r;
   logic [15:0] prev_r;
   logic [1:0] pollReads_r;
   logic [PW-1:0] pollCnt_r;
   logic bypass_r, failed_r, refused_r, failSeen_r;
   logic [37:0] cur;
   logic curLast, curRead, cycDone, ctrlWr, legal, toggled, pollFail;
   logic [15:0] cycRdata;

   assign cur = seqStep(op_r, step_r, addr_r, data_r);
   assign curLast = cur[37];
   assign curRead = cur[36];
   assign opIn = op_t'(regWdata[`OP_MSB:0]);
   assign ctrlWr = regWr && regAddr == `REG_CTRL;
   // in bypass only the short program and the exit are meaningful
   assign legal = regWdata[`OP_MSB:0] <= OP_QUERY &&
                  (bypass_r ? (opIn == OP_BYP_PROG || opIn == OP_BYP_EXIT)
                            : (opIn != OP_BYP_PROG && opIn != OP_BYP_EXIT));
   assign toggled = cycRdata[`ST_TOGGLE_BIT] != prev_r[`ST_TOGGLE_BIT];
   assign pollFail = (failSeen_r && cycRdata[`ST_FAIL_BIT]) ||
                     pollCnt_r == PW'(MAX_POLLS);

   flash_bus_cycle u_cycle (
      .mclk(mclk),
      .rst(rst),
      .start(state_r == ST_ISSUE),
      // polls and the final read use the target address
      .write(phase_r == PH_SEQ && !curRead),
      .addr(phase_r == PH_SEQ ? cur[35:16] : addr_r),
      .wdata(cur[15:0]),
      .done(cycDone),
      .rdata(cycRdata),
      .flashAddr(flashAddr),
      .flashDqOut(flashDqOut),
      .flashDqOe(flashDqOe),
      .flashDqIn(flashDqIn),
      .flashCeN(flashCeN),
      .flashWeN(flashWeN),
      .flashOeN(flashOeN)
   );

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         phase_r <= PH_SEQ;
         op_r <= OP_READ;
         step_r <= 3'd0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (ctrlWr && legal) begin
                  op_r <= opIn;
                  step_r <= 3'd0;
                  phase_r <= PH_SEQ;
                  state_r <= ST_ISSUE;
               end
            end
            ST_ISSUE: state_r <= ST_WAIT;
            ST_WAIT: begin
               if (cycDone) begin
                  state_r <= ST_ISSUE;
                  unique case (phase_r)
                     PH_SEQ: begin
                        if (!curLast) begin
                           step_r <= step_r + 3'd1;
                        end else if (polls(op_r)) begin
                           phase_r <= PH_POLL;
                        end else begin
                           state_r <= ST_IDLE;
                        end
                     end
                     PH_POLL: begin
                        // two reads in a row decide whether bit 6 still toggles
                        if (pollReads_r != 2'd0 && !toggled) begin
                           phase_r <= PH_FINAL;
                        end else if (pollReads_r != 2'd0 && pollFail) begin
                           op_r <= OP_RESET;
                           step_r <= 3'd0;
                           phase_r <= PH_SEQ;
                        end
                     end
                     PH_FINAL: state_r <= ST_IDLE;
                  endcase
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // poll tracking
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         prev_r <= 16'h0000;
         pollReads_r <= 2'd0;
         pollCnt_r <= '0;
         failSeen_r <= 1'b0;
      end else if (state_r == ST_IDLE) begin
         pollReads_r <= 2'd0;
         pollCnt_r <= '0;
         failSeen_r <= 1'b0;
      end else if (cycDone && phase_r == PH_POLL) begin
         prev_r <= cycRdata;
         pollReads_r <= (pollReads_r == 2'd2) ? 2'd2 : pollReads_r + 2'd1;
         pollCnt_r <= pollCnt_r + PW'(1);
         // toggling with bit 5 high forces one more comparison before failing
         if (toggled && cycRdata[`ST_FAIL_BIT]) begin
            failSeen_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   // target address and data are frozen while an operation runs
   always_ff @(posedge mclk) begin
      if (rst) begin
         addr_r <= 20'h00000;
         data_r <= 16'h0000;
      end else if (regWr && state_r == ST_IDLE) begin
         if (regAddr == `REG_ADDR) begin
            addr_r <= regWdata[19:0];
         end
         if (regAddr == `REG_DATA) begin
            data_r <= regWdata[15:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bypass_r <= 1'b0;
         failed_r <= 1'b0;
         refused_r <= 1'b0;
         result_r <= 16'h0000;
      end else begin
         if (ctrlWr) begin
            refused_r <= !(legal && state_r == ST_IDLE);
            if (legal && state_r == ST_IDLE) begin
               failed_r <= 1'b0;
            end
         end
         if (state_r == ST_WAIT && cycDone) begin
            if (phase_r == PH_POLL && pollReads_r != 2'd0 && toggled && pollFail) begin
               failed_r <= 1'b1;
            end
            if (phase_r == PH_FINAL || (phase_r == PH_SEQ && curLast && curRead)) begin
               result_r <= cycRdata;
            end
            if (phase_r == PH_SEQ && curLast && op_r == OP_BYP_ENTER) begin
               bypass_r <= 1'b1;
            end
            if (phase_r == PH_SEQ && curLast && op_r == OP_BYP_EXIT) begin
               bypass_r <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         regRdata <= 32'h00000000;
      end else if (regRd) begin
         case (regAddr)
            `REG_CTRL: regRdata <= {28'h0000000, op_r};
            `REG_ADDR: regRdata <= {12'h000, addr_r};
            `REG_DATA: regRdata <= {16'h0000, data_r};
            `REG_STATUS: regRdata <= {`STATUS_PAD'h0, readyBusyN, bypass_r, refused_r,
                                      failed_r, state_r != ST_IDLE};
            `REG_RESULT: regRdata <= {16'h0000, result_r};
            default: regRdata <= 32'h00000000;
         endcase
      end else begin
         regRdata <= 32'h00000000;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_seq_reads_only_when_listed;
      @(posedge mclk) disable iff (rst)
      (!flashOeN && phase_r == PH_SEQ) |-> curRead;
   endproperty
   a_seq_reads_only_when_listed: assert property (p_seq_reads_only_when_listed)
      else $error("read strobe during a command write step");

   property p_fail_sends_reset;
      @(posedge mclk) disable iff (rst)
      (state_r == ST_WAIT && cycDone && phase_r == PH_POLL && pollReads_r != 2'd0 && toggled
       && pollFail) |=> (op_r == OP_RESET && phase_r == PH_SEQ && failed_r) ##1 !flashCeN;
   endproperty
   a_fail_sends_reset: assert property (p_fail_sends_reset)
      else $error("failure did not lead to a reset command");

   property p_bypass_prog_refused;
      @(posedge mclk) disable iff (rst)
      (state_r == ST_IDLE && ctrlWr && opIn == OP_BYP_PROG && !bypass_r)
         |=> (state_r == ST_IDLE && refused_r);
   endproperty
   a_bypass_prog_refused: assert property (p_bypass_prog_refused)
      else $error("short program issued outside bypass");

   property p_poll_at_target;
      @(posedge mclk) disable iff (rst)
      (phase_r != PH_SEQ && !flashOeN) |-> flashAddr == addr_r;
   endproperty
   a_poll_at_target: assert property (p_poll_at_target)
      else $error("status read away from the target address");

   property p_final_read_before_idle;
      @(posedge mclk) disable iff (rst)
      (state_r == ST_IDLE && $past(state_r) == ST_WAIT && polls(op_r))
         |-> ($past(phase_r) == PH_FINAL || failed_r);
   endproperty
   a_final_read_before_idle: assert property (p_final_read_before_idle)
      else $error("operation finished without a trailing data read");

   property p_two_reads_before_done;
      @(posedge mclk) disable iff (rst)
      $rose(phase_r == PH_FINAL) |-> pollReads_r == 2'd2;
   endproperty
   a_two_reads_before_done: assert property (p_two_reads_before_done)
      else $error("toggle decision taken on fewer than two reads");

   c_program_done: cover property (@(posedge mclk) disable iff (rst)
      phase_r == PH_FINAL && cycDone && op_r == OP_PROG);
   c_fail_reset: cover property (@(posedge mclk) disable iff (rst)
      failed_r && op_r == OP_RESET && state_r == ST_IDLE);
   c_bypass_prog: cover property (@(posedge mclk) disable iff (rst)
      bypass_r && op_r == OP_BYP_PROG && phase_r == PH_FINAL);

endmodule

// *** test/flash_model.sv ***
// flash device model: command decoder, small array, status bits, ready/busy
// assumes word-mode strobes from the host; stuck makes a program never finish
module flash_model #(
   parameter logic [7:0] PROT_SECT = 8'h05,
   parameter logic [15:0] QRY_WORD = 16'h0a5c // arbitrary query marker
) (
   input wire logic [19:0] flashAddr,
   input wire logic [15:0] flashDqOut,
   input wire logic flashDqOe,
   input wire logic flashCeN,
   input wire logic flashWeN,
   input wire logic flashOeN,
   input wire logic stuck,
   output logic [15:0] flashDqIn,
   output logic readyBusyN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [logic [19:0]];
   logic [19:0] wa;
   logic [15:0] rd = 16'h0;
   logic [15:0] progData = 16'h0;
   logic [7:0] es;
   int cyc = 0;
   int left = 0;
   logic tog = 0;
   logic asel = 0;
   logic byp = 0;
   logic ers = 0;
   logic sus = 0;
   logic tog2 = 0;
   logic qry = 0;
   initial begin
      mem[20'h01234] = 16'h5a3c;
      mem[20'h05020] = 16'h0f0f;
   end
   // released bus shows the inverse, so stale data never passes as good
   // a bus still driven by the host during a read garbles the data
   assign flashDqIn = (!flashCeN && !flashOeN && !flashDqOe) ? rd : ~rd;
   assign readyBusyN = (left == 0) || sus;
   task automatic prog(input logic [19:0] a, input logic [15:0] d);
      progData = d;
      ers = 0;
      left = 3;
      if (a[19:12] != PROT_SECT) mem[a] = d;
   endtask
   task automatic erase(input logic [7:0] s, input logic all);
      es = s;
      ers = 1;
      left = 4;
      foreach (mem[k])
         if ((all || k[19:12] == s) && k[19:12] != PROT_SECT) mem[k] = 16'hffff;
   endtask
   always @(negedge flashWeN) if (!flashCeN) wa = flashAddr;
   always @(posedge flashWeN) if (!flashCeN && flashDqOe) begin
      if (flashDqOut == 16'h00f0 && !byp) begin
         asel = 0;
         qry = 0;
         cyc = 0;
         left = 0;
      end else if (byp) begin
         if (cyc == 9) begin
            prog(wa, flashDqOut);
            cyc = 0;
         end else if (flashDqOut == 16'h00a0) cyc = 9;
         else if (flashDqOut == 16'h0090) cyc = 8;
         else if (cyc == 8) begin
            byp = 0;
            cyc = 0;
         end
      end else case (cyc)
         0: begin
            cyc = (wa[10:0] == 11'h555 && flashDqOut == 16'h00aa) ? 1 : 0;
            if (wa[10:0] == 11'h055 && flashDqOut == 16'h0098 && left == 0) qry = 1;
            if (flashDqOut == 16'h00b0 && ers && left > 0) sus = 1;
            if (flashDqOut == 16'h0030) sus = 0;
         end
         1: cyc = (wa[10:0] == 11'h2aa && flashDqOut == 16'h0055) ? 2 : 0;
         2: begin
            cyc = flashDqOut == 16'h00a0 ? 9 : flashDqOut == 16'h0080 ? 3 : 0;
            asel = flashDqOut == 16'h0090;
            byp = flashDqOut == 16'h0020;
         end
         3, 4: cyc = cyc + 1;
         5: begin
            erase(wa[19:12], flashDqOut == 16'h0010);
            cyc = 0;
         end
         default: begin
            prog(wa, flashDqOut);
            cyc = 0;
         end
      endcase
   end
   always @(negedge flashOeN) if (!flashCeN) begin
      if (sus && flashAddr[19:12] == es) begin
         // suspended: bit 7 high, bit 6 frozen, bit 2 still marks the sector
         tog2 = ~tog2;
         rd = {8'h0, 1'b1, tog, 3'b000, tog2, 2'b00};
      end else if (left > 0 && !sus) begin
         tog = ~tog;
         rd = 16'h0;
         rd[6] = tog;
         rd[5] = stuck;
         rd[7] = ers ? 1'b0 : ~progData[7];
         rd[2] = (ers && flashAddr[19:12] == es) ? tog : 1'b0;
         if (!stuck) left = left - 1;
      end else if (qry) rd = QRY_WORD;
      else if (asel && flashAddr[7:0] == 8'h02)
         rd = {15'h0, flashAddr[19:12] == PROT_SECT};
      else rd = mem.exists(flashAddr) ? mem[flashAddr] : 16'hffff;
   end
endmodule

// *** test/tb.sv ***
// self-checking bench of the flash host controller against the device model
// assumes the controller's register map and op codes as handed over
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst = 1, regWr = 0, regRd = 0, stuck = 0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0, regRdata, v;
   logic [19:0] flashAddr;
   logic [15:0] flashDqOut, flashDqIn;
   logic flashDqOe, flashCeN, flashWeN, flashOeN, readyBusyN;
   int err_total = 0, n_checks = 0;
   localparam logic [15:0] QRY = 16'h0a5c; // arbitrary query marker handed to the model
   always #5 mclk = ~mclk;
   // stuck-program case fails on bit 5 within three polls, before this short poll limit
   flash_host_ctrl #(.MAX_POLLS(8)) dut_u (.mclk(mclk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
      .flashDqIn(flashDqIn), .flashCeN(flashCeN), .flashWeN(flashWeN),
      .flashOeN(flashOeN), .readyBusyN(readyBusyN));
   flash_model #(.QRY_WORD(QRY)) dev_u (.flashAddr(flashAddr), .flashDqOut(flashDqOut),
      .flashDqOe(flashDqOe), .flashCeN(flashCeN),
      .flashWeN(flashWeN), .flashOeN(flashOeN), .stuck(stuck), .flashDqIn(flashDqIn),
      .readyBusyN(readyBusyN));
   // ----------------------------------------
   // register access and checking
   // ----------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      v = regRdata;
   endtask
   task automatic res(input string nm, input logic [31:0] e);
      rd(8'h10);
      chk(nm, v, e);
   endtask
   task automatic stat(input logic [31:0] e);
      rd(8'h0c);
      chk("status", v, e);
   endtask
   // waits out busy; a hang counts as a mismatch
   task automatic run(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d);
      int n;
      wr(8'h04, {12'h0, a});
      wr(8'h08, {16'h0, d});
      wr(8'h00, {28'h0, o});
      n = 0;
      do begin
         rd(8'h0c);
         n++;
      end while (v[0] !== 1'b0 && n < 400);
      if (n >= 400) begin
         err_total++;
         test_done();
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      stat(32'h10);
      rd(8'h20);
      chk("unmapped", v, 32'h0);
      run(4'h0, 20'h01234, 16'h0);
      res("array", 32'h5a3c);
      run(4'h1, 20'h03000, 16'h00c3);
      res("program", 32'h00c3);
      stat(32'h10);
      run(4'h1, 20'h05010, 16'h1234);
      res("prot program", 32'hffff);
      run(4'h2, 20'h03000, 16'h0);
      res("erase", 32'hffff);
      run(4'h2, 20'h05000, 16'h0);
      run(4'h0, 20'h05020, 16'h0);
      res("prot erase", 32'h0f0f);
      run(4'ha, 20'h05000, 16'h0);
      res("verify prot", 32'h1);
      run(4'ha, 20'h03000, 16'h0);
      res("verify free", 32'h0);
      run(4'h4, 20'h0, 16'h0);
      run(4'h5, 20'h0, 16'h0);
      stat(32'h18);
      run(4'h1, 20'h03004, 16'h0077);
      stat(32'h1c);
      run(4'h6, 20'h03004, 16'h0077);
      run(4'h7, 20'h0, 16'h0);
      stat(32'h10);
      run(4'h0, 20'h03004, 16'h0);
      res("bypass program", 32'h0077);
      stuck <= 1'b1;
      run(4'h1, 20'h03008, 16'h0001);
      stat(32'h12);
      stuck <= 1'b0;
      run(4'h0, 20'h03008, 16'h0);
      res("after reset", 32'h0001);
      run(4'h6, 20'h03000, 16'h0);
      stat(32'h14);
      run(4'hb, 20'h00010, 16'h0);
      res("query", {16'h0, QRY});
      run(4'h4, 20'h0, 16'h0);
      run(4'h9, 20'h0, 16'h0);
      run(4'h8, 20'h0, 16'h0);
      run(4'h3, 20'h0, 16'h0);
      run(4'h0, 20'h01234, 16'h0);
      res("chip erase", 32'hffff);
      run(4'h0, 20'h05020, 16'h0);
      res("chip erase prot", 32'h0f0f);
      test_done();
   end
   initial begin
      repeat (40000) @(posedge mclk);
      err_total++;
      test_done();
   end
endmodule
